/* File: rtl/io_expander_map.vh */
// constants for the i2c quasi-bidirectional io expander
`ifndef IO_EXPANDER_MAP_VH
`define IO_EXPANDER_MAP_VH
`define FIXED_ADDR_VARIANT0 4'h4
`define FIXED_ADDR_VARIANT1 4'h7
`define PORT_RESET_VALUE    8'hff
`define RW_BIT_POS          0
`define BIT_COUNT_LAST      4'h7
`endif

/* File: rtl/i2c_quasi_bidir_io_expander.v */
// i2c slave with eight quasi-bidirectional port pins behind one register
`timescale 1ns/100ps
`include "io_expander_map.vh"
module i2c_quasi_bidir_io_expander #(
  parameter VARIANT = 0
) (
  // system
  input  wire       clk,
  input  wire       nrst,
  // i2c bus
  input  wire       scl_in,
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  // address straps
  input  wire       addr_strap_bit0,
  input  wire       addr_strap_bit1,
  input  wire       addr_strap_bit2,
  // port pins
  input  wire [7:0] port_pin_in,
  output wire [7:0] port_pin_out,
  output wire [7:0] port_sink_oe,
  output wire [7:0] port_boost_oe,
  // interrupt, open drain
  output wire       int_n_out,
  output wire       int_n_oe
);

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [1:0] scl_s_q;
  reg [1:0] sda_s_q;
  reg [1:0] strap0_s_q, strap1_s_q, strap2_s_q;
  reg [7:0] pin_s1_q, pin_s2_q;
  reg       scl_prev_q, sda_prev_q;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s_q    <= 2'h3;
      sda_s_q    <= 2'h3;
      strap0_s_q <= 2'h0;
      strap1_s_q <= 2'h0;
      strap2_s_q <= 2'h0;
      pin_s1_q   <= 8'hff;
      pin_s2_q   <= 8'hff;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_s_q    <= {scl_s_q[0], scl_in};
      sda_s_q    <= {sda_s_q[0], sda_in};
      strap0_s_q <= {strap0_s_q[0], addr_strap_bit0};
      strap1_s_q <= {strap1_s_q[0], addr_strap_bit1};
      strap2_s_q <= {strap2_s_q[0], addr_strap_bit2};
      pin_s1_q   <= port_pin_in;
      pin_s2_q   <= pin_s1_q;
      scl_prev_q <= scl_s_q[1];
      sda_prev_q <= sda_s_q[1];
    end
  end

  wire scl      = scl_s_q[1];
  wire sda      = sda_s_q[1];
  wire scl_rise = scl & ~scl_prev_q;
  wire scl_fall = ~scl & scl_prev_q;
  wire start_c  = scl & scl_prev_q & sda_prev_q & ~sda;
  wire stop_c   = scl & scl_prev_q & ~sda_prev_q & sda;

  // fixed part chosen by variant, low bits from straps
  wire [3:0] fixed_part = (VARIANT != 0) ? `FIXED_ADDR_VARIANT1
                                         : `FIXED_ADDR_VARIANT0;
  wire [6:0] own_addr = {fixed_part, strap2_s_q[1], strap1_s_q[1],
                         strap0_s_q[1]};

  // ****************************************
  // protocol engine
  // ****************************************
  localparam ST_IDLE = 5'h01;
  localparam ST_ADDR = 5'h02;
  localparam ST_WR   = 5'h04;
  localparam ST_RD   = 5'h08;
  localparam ST_MACK = 5'h10;

  reg [4:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg       ack_q;     // device drives ack bit
  reg       ack_wr_q;  // ack belongs to a data byte of a write
  reg [7:0] port_q;
  reg [7:0] boost_q;
  reg       boost_en_q;
  reg       tx_q;      // device drives a data bit
  reg [7:0] last_in_q;
  reg       int_q;
  reg       sda_drv_q;

  wire [7:0] pin_now = pin_s2_q;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      ack_q      <= 1'b0;
      ack_wr_q   <= 1'b0;
      port_q     <= `PORT_RESET_VALUE;
      boost_q    <= 8'h00;
      boost_en_q <= 1'b0;
      tx_q       <= 1'b0;
      last_in_q  <= 8'hff;
      int_q      <= 1'b0;
      sda_drv_q  <= 1'b0;
    end else begin
      // change against captured state raises; equality clears
      if (pin_now != last_in_q)
        int_q <= 1'b1;
      else
        int_q <= 1'b0;
      if (start_c) begin
        state_q   <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        ack_q     <= 1'b0;
        tx_q      <= 1'b0;
        sda_drv_q <= 1'b0;
      end else if (stop_c) begin
        state_q   <= ST_IDLE;
        ack_q     <= 1'b0;
        tx_q      <= 1'b0;
        sda_drv_q <= 1'b0;
      end else begin
        // accelerator only while scl high in the write ack bit
        if (scl_rise && ack_q && ack_wr_q) begin
          boost_en_q <= 1'b1;
          boost_q    <= shift_q;
        end
        if (scl_fall)
          boost_en_q <= 1'b0;
        case (state_q)
          ST_IDLE: begin
            sda_drv_q <= 1'b0;
          end
          ST_ADDR, ST_WR: begin
            if (scl_rise && !ack_q) begin
              shift_q   <= {shift_q[6:0], sda};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (scl_fall && ack_q) begin
              ack_q     <= 1'b0;
              sda_drv_q <= 1'b0;
              ack_wr_q  <= 1'b0;
              bit_cnt_q <= 4'h0;
              if (ack_wr_q) begin
                // ack done: apply byte, msb to pin 7
                port_q    <= shift_q;
                last_in_q <= pin_now;
                int_q     <= 1'b0;
              end
              if (state_q == ST_ADDR) begin
                if (shift_q[`RW_BIT_POS]) begin
                  state_q   <= ST_RD;
                  shift_q   <= pin_now;
                  last_in_q <= pin_now;
                  int_q     <= 1'b0;
                  tx_q      <= 1'b1;
                  sda_drv_q <= ~pin_now[7];
                end else begin
                  state_q <= ST_WR;
                end
              end
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              if (state_q == ST_ADDR && shift_q[7:1] != own_addr) begin
                state_q <= ST_IDLE;
              end else begin
                ack_q     <= 1'b1;
                ack_wr_q  <= (state_q == ST_WR);
                sda_drv_q <= 1'b1;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt_q == `BIT_COUNT_LAST) begin
                state_q   <= ST_MACK;
                tx_q      <= 1'b0;
                sda_drv_q <= 1'b0;
                bit_cnt_q <= 4'h0;
              end else begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                shift_q   <= {shift_q[6:0], 1'b1};
                sda_drv_q <= ~shift_q[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              ack_wr_q <= sda; // holds the master nack
            end
            if (scl_fall) begin
              if (!ack_wr_q) begin
                state_q   <= ST_RD;
                shift_q   <= pin_now;
                last_in_q <= pin_now;
                int_q     <= 1'b0;
                tx_q      <= 1'b1;
                sda_drv_q <= ~pin_now[7];
              end else begin
                state_q <= ST_IDLE;
              end
              ack_wr_q <= 1'b0;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // the sink may clamp a pin the master later reads as input,
  // so a 1 must be written first
  // sink yields to the boost so a 0-to-1 write never fights itself
  assign port_sink_oe  = ~port_q & ~port_boost_oe;
  assign port_pin_out  = 8'h00;
  // weak pull-up is external to this logic; boost drives high
  assign port_boost_oe = boost_en_q ? boost_q : 8'h00;
  assign sda_out       = 1'b0;
  assign sda_oe        = sda_drv_q;
  assign int_n_out     = 1'b0;
  assign int_n_oe      = int_q;
  wire   unused_tx     = tx_q;

endmodule // i2c_quasi_bidir_io_expander

/* File: verification/io_expander_props.sv */
// concurrent checks on the io expander ports
`timescale 1ns/100ps
module io_expander_props (
  // watched ports
  input wire       clk,
  input wire       nrst,
  input wire       scl_in,
  input wire       sda_out,
  input wire       sda_oe,
  input wire [7:0] port_pin_in,
  input wire [7:0] port_pin_out,
  input wire [7:0] port_sink_oe,
  input wire [7:0] port_boost_oe,
  input wire       int_n_out,
  input wire       int_n_oe
);
  // ****************
  // helper and rules
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  reg [3:0] quiet_q;  // saturates so a long idle never wraps to zero
  always @(posedge clk or negedge nrst)
    if (!nrst) quiet_q <= 4'hf;
    else if ($changed(port_pin_in)) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  sequence s_boost_hold;
    port_boost_oe != 8'h00 [*2];
  endsequence
  property p_drive_low;
    sda_out == 1'b0 && port_pin_out == 8'h00 && int_n_out == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("driven level high");
  property p_excl;
    (port_sink_oe & port_boost_oe) == 8'h00;
  endproperty
  a_excl: assert property (p_excl) else $error("sink and boost together");
  property p_boost_ack;
    $rose(|port_boost_oe) |-> sda_oe;
  endproperty
  a_boost_ack: assert property (p_boost_ack) else $error("boost off ack");
  property p_boost_short;
    $rose(|port_boost_oe) |-> s_boost_hold ##[1:6] port_boost_oe == 8'h00;
  endproperty
  a_boost_short: assert property (p_boost_short) else $error("boost length");
  property p_sink_at_ack;
    $changed(port_sink_oe) |-> sda_oe || $past(sda_oe);
  endproperty
  a_sink_at_ack: assert property (p_sink_at_ack) else $error("sink moved");
  property p_oe_rise;
    $rose(sda_oe) |-> !scl_in;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("sda pulled in high");
  property p_oe_fall;
    $fell(sda_oe) |-> !scl_in;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("sda freed in high");
  property p_int_cause;
    $rose(int_n_oe) |-> quiet_q < 4'h8;
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("int no cause");
endmodule  // io_expander_props
bind i2c_quasi_bidir_io_expander io_expander_props i_props (.clk, .nrst,
  .scl_in, .sda_out, .sda_oe, .port_pin_in, .port_pin_out, .port_sink_oe,
  .port_boost_oe, .int_n_out, .int_n_oe);

/* File: verification/i2c_master_model.sv */
// i2c bus master model driving the expander
`timescale 1ns/100ps
module i2c_master_model (
  // bench side
  input  wire clk,
  input  wire sda_oe,
  // bus lines
  output reg  scl,
  output wire sda
);
  reg sda_m;
  assign sda = sda_m & ~sda_oe;  // pull-up unless a party sinks
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // scl stands high between frames, a quarter bit is two clocks
  task q;
    repeat (2) @(negedge clk);
  endtask
  task start;
    sda_m = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask
  task bit_io(input b, output r);
    sda_m = b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask
  // read passes 8'hff so the data line is released
  task xfer(input [7:0] d, input ack_in, output [7:0] r, output ack);
    integer i;
    for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r[i]);
    bit_io(ack_in, ack);
  endtask
  task stop;
    sda_m = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_m = 1'b1;
    q;
  endtask
endmodule  // i2c_master_model

/* File: verification/tb.sv */
// self-checking bench for the io expander
`timescale 1ns/100ps
module tb;
  reg        clk, nrst, ack;
  reg  [7:0] ext_q, rd;
  reg  [7:0] boost_acc = 8'h00;
  integer    err_count, total_checks;
  wire       scl, sda, sda_out, sda_oe, int_n_out, int_n_oe;
  wire [7:0] pin_out, sink, boost;
  wire [7:0] pins = ~sink & ext_q;  // a sinking pin reads low
  i2c_master_model i_master (.clk(clk), .sda_oe(sda_oe), .scl(scl),
    .sda(sda));
  i2c_quasi_bidir_io_expander #(.VARIANT(0)) i_dut (.clk(clk), .nrst(nrst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(1'b1), .addr_strap_bit1(1'b0), .addr_strap_bit2(1'b1),
    .port_pin_in(pins), .port_pin_out(pin_out), .port_sink_oe(sink),
    .port_boost_oe(boost), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) boost_acc <= boost_acc | boost;
  // ****************
  // checks and tasks
  // ****************
  task chk(input [7:0] got, input [7:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task t_write;
    i_master.start;
    i_master.xfer(8'h4a, 1'b1, rd, ack);
    chk({7'h00, ack}, 8'h00);
    i_master.xfer(8'h5a, 1'b1, rd, ack);
    repeat (2) @(negedge clk);
    chk(sink, 8'ha5);
    i_master.xfer(8'h0f, 1'b1, rd, ack);
    repeat (2) @(negedge clk);
    chk(sink, 8'hf0);
    chk(boost_acc, 8'h5f);
    i_master.stop;
  endtask
  task t_bad;
    i_master.start;
    i_master.xfer(8'h7a, 1'b1, rd, ack);
    chk({7'h00, ack}, 8'h01);
    i_master.xfer(8'h00, 1'b1, rd, ack);
    i_master.stop;
    chk(sink, 8'hf0);
  endtask
  task t_read(input [7:0] exp);
    chk({7'h00, int_n_oe}, 8'h01);
    i_master.start;
    i_master.xfer(8'h4b, 1'b1, rd, ack);
    chk({7'h00, ack}, 8'h00);
    i_master.xfer(8'hff, 1'b0, rd, ack);
    chk(rd, exp);
    i_master.xfer(8'hff, 1'b1, rd, ack);
    i_master.stop;
    chk(rd, exp);
    chk({7'h00, int_n_oe}, 8'h00);
  endtask
  task t_int;
    ext_q = 8'h3c;
    repeat (8) @(negedge clk);
    chk({7'h00, int_n_oe}, 8'h01);
  endtask
  initial begin
    nrst = 1'b0;
    ext_q = 8'hff;
    err_count = 0;
    total_checks = 0;
    repeat (16) @(negedge clk);
    chk(sink | boost, 8'h00);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_write;
    t_bad;
    t_read(8'h0f);
    t_int;
    t_read(8'h0c);
    finish_test;
  end
  initial begin
    #2000000;
    err_count = err_count + 1;
    finish_test;
  end
endmodule  // tb
